// >>> hdl/gpio_port_map.svh
/*
 * Register offsets, field positions and reset values of the eight-pin port.
 * Assumes a 12-bit byte address decoded from the AHB-Lite HADDR bus.
 */
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define GP_DATA_WINDOW 2'b00
`define GP_OFS_DIR_CMD 12'h400
`define GP_OFS_ADC_SET 12'h404
`define GP_OFS_ADC_CLR 12'h408
`define GP_OFS_DMA_SET 12'h40C
`define GP_OFS_DMA_CLR 12'h410
`define GP_OFS_PAD_EN 12'h414
`define GP_OFS_SENSE 12'h418
`define GP_OFS_INT_EN 12'h41C
`define GP_OFS_INT_STAT 12'h420
`define GP_OFS_INT_MSTAT 12'h424

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define GP_DATA_MASK_LSB 2
`define GP_DIR_MODE_LSB 8
`define GP_SENSE_BOTH_LSB 8
`define GP_SENSE_HIGH_LSB 16

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define GP_RST_PINS 8'h00
`define GP_RST_WORD 32'h0000_0000

`endif

// >>> hdl/gpio_port_pkg.sv
/*
 * Types shared by the port design files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpio_port_pkg;

    // ------------------------------------------------------------
    // Pin direction and control settings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DIR_SW_INPUT = 2'b00,
        DIR_SW_OUTPUT = 2'b01,
        DIR_HARDWARE_CONTROL = 2'b10
    } pin_direction_setting_t;

    // ------------------------------------------------------------
    // Bus slave data phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ = 2'b10,
        PH_READ_DONE = 2'b11
    } bus_phase_t;

endpackage

// >>> hdl/gpio_ahb_front.sv
/*
 * AHB-Lite slave front end: turns transfers into register strobes.
 * Assumes one slave on the bus, single word transfers, OKAY only.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_map.svh"

module gpio_ahb_front
    import gpio_port_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    input wire logic [31:0] rdata,
    output logic reg_wr,
    output logic [11:0] reg_addr
);

    bus_phase_t phase;

    // ------------------------------------------------------------
    // Data phase tracking
    // ------------------------------------------------------------
    // Reads take one wait state so that read data leave a flip-flop.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            phase <= PH_IDLE;
            reg_addr <= 12'h000;
        end
        else
        begin
            case (phase)
                PH_READ: phase <= PH_READ_DONE;
                default:
                begin
                    if (hready && hsel && htrans[1])
                    begin
                        phase <= hwrite ? PH_WRITE : PH_READ;
                        reg_addr <= haddr;
                    end
                    else if (hready)
                    begin
                        phase <= PH_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            hrdata <= `GP_RST_WORD;
        end
        else if (phase == PH_READ)
        begin
            hrdata <= rdata;
        end
    end

    assign hreadyout = (phase != PH_READ);
    assign reg_wr = (phase == PH_WRITE);

endmodule

`default_nettype wire

// >>> hdl/gpio_event_detect.sv
/*
 * Per-pin event detection with edge or level sensing.
 * Assumes pin values already synchronous to CLK.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_map.svh"

module gpio_event_detect
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [7:0] pin_value,
    input wire logic [7:0] sense_level,
    input wire logic [7:0] both_edges,
    input wire logic [7:0] high_rising,
    output logic [7:0] event_start,
    output logic [7:0] level_active
);

    logic [7:0] prev_value;
    logic [7:0] edge_hit;
    logic [7:0] prev_level;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            prev_value <= `GP_RST_PINS;
        end
        else
        begin
            prev_value <= pin_value;
        end
    end

    // A level condition fires one event when it starts, then holds status.
    assign level_active = ~(pin_value ^ high_rising);
    assign prev_level = ~(prev_value ^ high_rising);
    assign edge_hit = (pin_value ^ prev_value) & (both_edges | ~(pin_value ^ high_rising));
    assign event_start = (sense_level & level_active & ~prev_level) | (~sense_level & edge_hit);

endmodule

`default_nettype wire

// >>> hdl/gpio_port.sv
/*
 * Eight-pin port: direction and control, pad gating, masked data access,
 * converter and DMA triggers, and the pin interrupt that runs beside them.
 * Assumes AHB-Lite on the register side, pins synchronous to CLK, and an
 * alternate peripheral that drives ALT_OUT and ALT_OE for hardware pins.
 */
// Our own choices: the AHB-Lite slave port and the register addresses.
// Operation
// - Each pin has its own converter-trigger enable, and while it is set the pin's events raise the converter start.
// - Clearing a pin's converter-trigger enable removes only that pin from the converter start and keeps the others.
// - Each pin has its own DMA-trigger enable, and while it is set the pin's events request a DMA start.
// - Clearing a pin's DMA-trigger enable removes only that pin from the DMA requests and keeps the others.
// - A pin that triggers the converter or DMA still raises its interrupt when that interrupt is enabled.
// - Each pin may be a software input, a software output or under hardware control, set for every masked pin.
// - A pin under hardware control takes direction and output value from the peripheral, not software.
// - Selection masks are eight bits with bit n for pin n, and only selected pins change on a write.
// - The direction and control setting of every pin can be read back.
// - A pin's signal passes between pad and port only while the pad is enabled for it.
// - After reset every pin is an ordinary port input.
// - Data reads and writes are masked by address bits, reading zero on unselected pins and writing only the selected ones.
// - The port has eight pins, each with its own direction, trigger and interrupt setting.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_map.svh"

module gpio_port
    import gpio_port_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE,
    input wire logic [7:0] ALT_OUT,
    input wire logic [7:0] ALT_OE,
    output logic [7:0] ALT_IN,
    output logic ADC_TRIG,
    output logic DMA_TRIG,
    output logic INT_REQ
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic reg_wr;
    logic [11:0] reg_addr;
    logic [31:0] rdata;
    logic [7:0] wmask;
    logic [7:0] data_mask;
    logic [7:0] out_dir;
    logic [7:0] hw_ctrl;
    logic [7:0] data_out;
    logic [7:0] pad_en;
    logic [7:0] adc_en;
    logic [7:0] dma_en;
    logic [7:0] sense_level;
    logic [7:0] both_edges;
    logic [7:0] high_rising;
    logic [7:0] int_en;
    logic [7:0] int_stat;
    logic [7:0] pin_value;
    logic [7:0] event_start;
    logic [7:0] level_active;
    logic [7:0] status_set;
    logic [7:0] status_clr;
    logic [7:0] next_oe;
    logic [7:0] next_out;
    logic [15:0] mode_code;
    pin_direction_setting_t mode_req;

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    // HSIZE is not decoded: only whole-word transfers are supported.
    gpio_ahb_front u_front (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .hsel(HSEL),
        .haddr(HADDR[11:0]),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hready(HREADY),
        .hreadyout(HREADYOUT),
        .hrdata(HRDATA),
        .rdata(rdata),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr)
    );

    assign HRESP = 1'b0;
    assign wmask = HWDATA[7:0];
    assign data_mask = reg_addr[`GP_DATA_MASK_LSB +: 8];
    assign mode_req = pin_direction_setting_t'(HWDATA[`GP_DIR_MODE_LSB +: 2]);

    // ------------------------------------------------------------
    // Direction and control
    // ------------------------------------------------------------
    // An unused mode code leaves every pin as it was.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            out_dir <= `GP_RST_PINS;
            hw_ctrl <= `GP_RST_PINS;
        end
        else if (reg_wr && reg_addr == `GP_OFS_DIR_CMD)
        begin
            case (mode_req)
                DIR_SW_INPUT:
                begin
                    out_dir <= out_dir & ~wmask;
                    hw_ctrl <= hw_ctrl & ~wmask;
                end
                DIR_SW_OUTPUT:
                begin
                    out_dir <= out_dir | wmask;
                    hw_ctrl <= hw_ctrl & ~wmask;
                end
                DIR_HARDWARE_CONTROL:
                begin
                    hw_ctrl <= hw_ctrl | wmask;
                end
                default:
                begin
                    hw_ctrl <= hw_ctrl;
                end
            endcase
        end
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_pin
            // Each pin keeps its own setting and reports it in two bits.
            assign mode_code[2*i +: 2] = hw_ctrl[i] ? DIR_HARDWARE_CONTROL :
                                         (out_dir[i] ? DIR_SW_OUTPUT : DIR_SW_INPUT);
        end
    endgenerate

    // ------------------------------------------------------------
    // Pad, data and pin paths
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pad_en <= `GP_RST_PINS;
        end
        else if (reg_wr && reg_addr == `GP_OFS_PAD_EN)
        begin
            pad_en <= HWDATA[7:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            data_out <= `GP_RST_PINS;
        end
        else if (reg_wr && reg_addr[11:10] == `GP_DATA_WINDOW)
        begin
            data_out <= (data_out & ~data_mask) | (HWDATA[7:0] & data_mask);
        end
    end

    // A disabled pad isolates the pin both ways, whatever the direction says.
    assign pin_value = PIN_IN & pad_en;
    assign next_oe = pad_en & ((hw_ctrl & ALT_OE) | (~hw_ctrl & out_dir));
    assign next_out = (hw_ctrl & ALT_OUT) | (~hw_ctrl & data_out);

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            PIN_OE <= `GP_RST_PINS;
            PIN_OUT <= `GP_RST_PINS;
            ALT_IN <= `GP_RST_PINS;
        end
        else
        begin
            PIN_OE <= next_oe;
            PIN_OUT <= next_out;
            ALT_IN <= pin_value;
        end
    end

    // ------------------------------------------------------------
    // Trigger enables
    // ------------------------------------------------------------
    // Set and clear offsets let software touch one pin without a read first.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            adc_en <= `GP_RST_PINS;
        end
        else if (reg_wr && reg_addr == `GP_OFS_ADC_SET)
        begin
            adc_en <= adc_en | wmask;
        end
        else if (reg_wr && reg_addr == `GP_OFS_ADC_CLR)
        begin
            adc_en <= adc_en & ~wmask;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            dma_en <= `GP_RST_PINS;
        end
        else if (reg_wr && reg_addr == `GP_OFS_DMA_SET)
        begin
            dma_en <= dma_en | wmask;
        end
        else if (reg_wr && reg_addr == `GP_OFS_DMA_CLR)
        begin
            dma_en <= dma_en & ~wmask;
        end
    end

    // ------------------------------------------------------------
    // Event sensing
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sense_level <= `GP_RST_PINS;
            both_edges <= `GP_RST_PINS;
            high_rising <= `GP_RST_PINS;
        end
        else if (reg_wr && reg_addr == `GP_OFS_SENSE)
        begin
            sense_level <= HWDATA[7:0];
            both_edges <= HWDATA[`GP_SENSE_BOTH_LSB +: 8];
            high_rising <= HWDATA[`GP_SENSE_HIGH_LSB +: 8];
        end
    end

    gpio_event_detect u_detect (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .pin_value(pin_value),
        .sense_level(sense_level),
        .both_edges(both_edges),
        .high_rising(high_rising),
        .event_start(event_start),
        .level_active(level_active)
    );

    // ------------------------------------------------------------
    // Triggers and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ADC_TRIG <= 1'b0;
            DMA_TRIG <= 1'b0;
        end
        else
        begin
            ADC_TRIG <= |(event_start & adc_en);
            DMA_TRIG <= |(event_start & dma_en);
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            int_en <= `GP_RST_PINS;
        end
        else if (reg_wr && reg_addr == `GP_OFS_INT_EN)
        begin
            int_en <= HWDATA[7:0];
        end
    end

    // A level source keeps setting its flag, so a clear only sticks once it ends.
    assign status_set = event_start | (sense_level & level_active);
    assign status_clr = (reg_wr && reg_addr == `GP_OFS_INT_STAT) ? wmask : 8'h00;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            int_stat <= `GP_RST_PINS;
        end
        else
        begin
            int_stat <= (int_stat & ~status_clr) | status_set;
        end
    end

    assign INT_REQ = |(int_stat & int_en);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rdata = `GP_RST_WORD;
        if (reg_addr[11:10] == `GP_DATA_WINDOW)
        begin
            rdata = {24'h00_0000, pin_value & data_mask};
        end
        else
        begin
            case (reg_addr)
                `GP_OFS_DIR_CMD: rdata = {16'h0000, mode_code};
                `GP_OFS_ADC_SET, `GP_OFS_ADC_CLR: rdata = {24'h00_0000, adc_en};
                `GP_OFS_DMA_SET, `GP_OFS_DMA_CLR: rdata = {24'h00_0000, dma_en};
                `GP_OFS_PAD_EN: rdata = {24'h00_0000, pad_en};
                `GP_OFS_SENSE: rdata = {8'h00, high_rising, both_edges, sense_level};
                `GP_OFS_INT_EN: rdata = {24'h00_0000, int_en};
                `GP_OFS_INT_STAT: rdata = {24'h00_0000, int_stat};
                `GP_OFS_INT_MSTAT: rdata = {24'h00_0000, int_stat & int_en};
                default: rdata = `GP_RST_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    logic dir_wr;
    logic data_wr;
    assign dir_wr = reg_wr && reg_addr == `GP_OFS_DIR_CMD;
    assign data_wr = reg_wr && reg_addr[11:10] == `GP_DATA_WINDOW;

    adc_cause_a: assert property (|(event_start & adc_en) |=> ADC_TRIG)
        else $error("converter trigger missed an enabled pin event");
    adc_source_a: assert property (ADC_TRIG |-> $past(|(event_start & adc_en)))
        else $error("converter trigger without an enabled pin event");
    dma_cause_a: assert property (|(event_start & dma_en) |=> DMA_TRIG)
        else $error("DMA trigger missed an enabled pin event");
    dma_source_a: assert property (DMA_TRIG |-> $past(|(event_start & dma_en)))
        else $error("DMA trigger without an enabled pin event");
    int_kept_a: assert property ((|(event_start & int_en)) && !reg_wr |=> INT_REQ)
        else $error("pin interrupt lost beside a trigger");
    dir_mask_a: assert property (dir_wr |=> ((out_dir ^ $past(out_dir)) & ~$past(wmask)) == 8'h00)
        else $error("direction write changed an unselected pin");
    hw_path_a: assert property (1'b1 |=> ((PIN_OUT ^ $past(ALT_OUT)) & $past(hw_ctrl)) == 8'h00)
        else $error("hardware pin not driven by the peripheral");
    pad_gate_a: assert property (1'b1 |=> (PIN_OE & ~$past(pad_en)) == 8'h00)
        else $error("pin driven with its pad disabled");
    reset_input_a: assert property ($rose(RESET_N) |-> out_dir == 8'h00 && hw_ctrl == 8'h00)
        else $error("pins not ordinary inputs after reset");
    data_mask_a: assert property (data_wr |=> ((data_out ^ $past(data_out)) & ~$past(data_mask)) == 8'h00)
        else $error("data write changed an unselected pin");
    trig_pulse_a: assert property (ADC_TRIG && $stable(pin_value) && $stable(high_rising) |=> !ADC_TRIG)
        else $error("level trigger longer than one cycle");

    adc_fire_c: cover property (ADC_TRIG && INT_REQ);
    dma_fire_c: cover property (DMA_TRIG);
    hw_mode_c: cover property (dir_wr && mode_req == DIR_HARDWARE_CONTROL);

endmodule

`default_nettype wire

// >>> dv/pin_side_model.sv
/*
 * Model of what stands outside the port: the pad wires and the alternate peripheral.
 * Assumes the bench sets the far-end drive of every pad through ext_drive.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_side_model
#(
    parameter logic [7:0] ALT_OUT_VALUE = 8'h55,
    parameter logic [7:0] ALT_OE_VALUE = 8'hAA
)
(
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_drive,
    output logic [7:0] pin_in,
    output logic [7:0] alt_out,
    output logic [7:0] alt_oe
);
    // ------------------------------------------------------------
    // Pad wire
    // ------------------------------------------------------------
    // The far end always drives weakly, so a pad the port releases never floats.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
    assign alt_out = ALT_OUT_VALUE;
    assign alt_oe = ALT_OE_VALUE;
endmodule

`default_nettype wire

// >>> dv/gpio_port_bench.sv
/*
 * Self-checking bench of the eight-pin port over AHB-Lite.
 * Assumes the register map of the shared header and a single bus slave.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_map.svh"

module gpio_port_bench
    import gpio_port_pkg::*;
;
    logic CLK, RESET_N, HSEL, HWRITE, HREADYOUT, HRESP, ADC_TRIG, DMA_TRIG, INT_REQ;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [7:0] PIN_IN, PIN_OUT, PIN_OE, ALT_OUT, ALT_OE, ALT_IN, ext;
    logic [31:0] exp_q[$];
    logic [1:0] dir_m[8];
    logic rd_pend, adc_d, dma_d;
    int n_mismatch, n_checks, adc_n, adc_hi, dma_n, dma_hi;

    gpio_port gpio_port_i (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
        .HRDATA(HRDATA), .HRESP(HRESP), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
        .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE), .ALT_IN(ALT_IN), .ADC_TRIG(ADC_TRIG),
        .DMA_TRIG(DMA_TRIG), .INT_REQ(INT_REQ));
    pin_side_model pin_side_model_i (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_drive(ext),
        .pin_in(PIN_IN), .alt_out(ALT_OUT), .alt_oe(ALT_OE));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // The master waits for hready at each phase; only the watchdog ends a stuck wait.
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {20'h0_0000, a};
        HWRITE <= wr;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HSEL <= 1'b0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] expv);
        exp_q.push_back(expv);
        ahb(1'b0, a, 32'h0000_0000);
    endtask

    function automatic logic [31:0] dir_word();
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int p = 0; p < 8; p++)
            w[2*p +: 2] = dir_m[p];
        return w;
    endfunction

    task automatic set_dir(input logic [7:0] m, input logic [1:0] mode);
        ahb(1'b1, `GP_OFS_DIR_CMD, {22'h0, mode, m});
        for (int p = 0; p < 8; p++)
            if (m[p] && mode != 2'b11)
                dir_m[p] = mode;
    endtask

    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(posedge CLK)
    begin
        if (RESET_N === 1'b1)
        begin
            if (rd_pend && HREADYOUT === 1'b1)
            begin
                rd_pend = 1'b0;
                check(HRDATA, exp_q.pop_front());
                check({31'h0, HRESP}, 32'h0000_0000);
            end
            if (HSEL && HTRANS[1] && HREADYOUT && !HWRITE)
                rd_pend = 1'b1;
            adc_hi += (ADC_TRIG === 1'b1);
            dma_hi += (DMA_TRIG === 1'b1);
            adc_n += (ADC_TRIG === 1'b1 && !adc_d);
            dma_n += (DMA_TRIG === 1'b1 && !dma_d);
            adc_d = ADC_TRIG;
            dma_d = DMA_TRIG;
        end
    end

    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    initial
    begin
        repeat (5000) @(posedge CLK);
        n_mismatch++;
        final_report();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        {HSEL, HWRITE, rd_pend, adc_d, dma_d} = 5'h00;
        HADDR = 32'h0000_0000;
        HWDATA = 32'h0000_0000;
        HTRANS = 2'b00;
        HSIZE = 3'b010;
        ext = 8'hC0;
        RESET_N = 1'b0;
        {n_mismatch, n_checks, adc_n, adc_hi, dma_n, dma_hi} = '0;
        for (int p = 0; p < 8; p++)
            dir_m[p] = DIR_SW_INPUT;
        void'($urandom(32'haa6ff309));
        repeat (12) @(posedge CLK);
        RESET_N <= 1'b1;
        check({24'h0, PIN_OE}, 32'h0000_0000);
        rd(`GP_OFS_DIR_CMD, 32'h0000_0000);
        rd(`GP_OFS_ADC_SET, 32'h0000_0000);
        $display("test reset done");
        // Random masks over every setting; unselected pins must keep what they had.
        for (int i = 0; i < 9; i++)
        begin
            set_dir(8'($urandom), 2'(i % 4));
            rd(`GP_OFS_DIR_CMD, dir_word());
        end
        $display("test direction done");
        set_dir(8'hFF, DIR_SW_INPUT);
        set_dir(8'h0F, DIR_SW_OUTPUT);
        set_dir(8'h30, DIR_HARDWARE_CONTROL);
        ahb(1'b1, {2'b00, 8'hFF, 2'b00}, 32'h0000_00A5);
        repeat (3) @(posedge CLK);
        check({24'h0, PIN_OE}, 32'h0000_0000);
        ahb(1'b1, `GP_OFS_PAD_EN, 32'h0000_00FF);
        repeat (3) @(posedge CLK);
        check({24'h0, PIN_OE}, 32'h0000_002F);
        check({24'h0, PIN_OUT & PIN_OE}, 32'h0000_0005);
        check({24'h0, ALT_IN}, 32'h0000_00C5);
        ahb(1'b1, {2'b00, 8'h0C, 2'b00}, 32'h0000_0000);
        repeat (3) @(posedge CLK);
        check({24'h0, PIN_OUT & PIN_OE}, 32'h0000_0001);
        rd({2'b00, 8'h03, 2'b00}, 32'h0000_0001);
        rd({2'b00, 8'hC0, 2'b00}, 32'h0000_00C0);
        ahb(1'b1, `GP_OFS_PAD_EN, 32'h0000_007F);
        repeat (3) @(posedge CLK);
        rd({2'b00, 8'hC0, 2'b00}, 32'h0000_0040);
        check({24'h0, ALT_IN}, 32'h0000_0041);
        $display("test pads done");
        ahb(1'b1, `GP_OFS_PAD_EN, 32'h0000_00FF);
        ahb(1'b1, `GP_OFS_SENSE, 32'h0040_0000);
        ext <= 8'h00;
        ahb(1'b1, `GP_OFS_ADC_SET, 32'h0000_0040);
        ahb(1'b1, `GP_OFS_DMA_SET, 32'h0000_0080);
        ahb(1'b1, `GP_OFS_INT_EN, 32'h0000_0040);
        ahb(1'b1, `GP_OFS_INT_STAT, 32'h0000_00FF);
        ext <= 8'h40;
        repeat (5) @(posedge CLK);
        check(32'(adc_n), 32'h0000_0001);
        check(32'(adc_hi), 32'h0000_0001);
        check(32'(dma_n), 32'h0000_0000);
        check({31'h0, INT_REQ}, 32'h0000_0001);
        rd(`GP_OFS_INT_MSTAT, 32'h0000_0040);
        ahb(1'b1, `GP_OFS_DMA_SET, 32'h0000_0040);
        ahb(1'b1, `GP_OFS_ADC_SET, 32'h0000_0080);
        ahb(1'b1, `GP_OFS_ADC_CLR, 32'h0000_0040);
        rd(`GP_OFS_ADC_SET, 32'h0000_0080);
        ext <= 8'h00;
        repeat (3) @(posedge CLK);
        ext <= 8'h40;
        repeat (5) @(posedge CLK);
        check(32'(adc_n), 32'h0000_0001);
        check(32'(dma_n), 32'h0000_0001);
        check(32'(dma_hi), 32'h0000_0001);
        ahb(1'b1, `GP_OFS_DMA_CLR, 32'h0000_0040);
        rd(`GP_OFS_DMA_SET, 32'h0000_0080);
        ext <= 8'h00;
        repeat (3) @(posedge CLK);
        ext <= 8'h40;
        repeat (5) @(posedge CLK);
        check(32'(dma_n + adc_n), 32'h0000_0002);
        ahb(1'b1, `GP_OFS_INT_STAT, 32'h0000_0040);
        repeat (3) @(posedge CLK);
        check({31'h0, INT_REQ}, 32'h0000_0000);
        $display("test triggers done");
        // A held high level on pin 7 fires one pulse, while its status keeps re-setting.
        ahb(1'b1, `GP_OFS_SENSE, 32'h0080_0080);
        ext <= 8'hC0;
        repeat (5) @(posedge CLK);
        check(32'(adc_hi), 32'h0000_0002);
        check(32'(dma_n), 32'h0000_0002);
        ahb(1'b1, `GP_OFS_INT_STAT, 32'h0000_0080);
        rd(`GP_OFS_INT_STAT, 32'h0000_0080);
        $display("test level sense done");
        final_report();
    end
endmodule

`default_nettype wire
